/* File: design/ccc_pkg.sv */
/*
 * Package for the configuration-memory CRC checker: widths, divider limits,
 * timing figures and default polynomial.
 * Assumes a single 250 MHz system clock domain.
 */
package ccc_pkg;
    localparam int CRC_W = 32;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_MAX = 4'h8;
    localparam int TICK_W = 9;
    localparam logic [TICK_W-1:0] TICK_ONE = 9'h001;
    // Undivided checker rate ceiling and system clock, both in kHz
    localparam int OSC_KHZ = 80000;
    localparam int SYS_KHZ = 250000;
    // System cycles per undivided checker step, rounded up so the step rate never exceeds the ceiling
    localparam int BASE_CYC_RAW = (SYS_KHZ + OSC_KHZ - 1) / OSC_KHZ;
    localparam int BASE_CYC = (BASE_CYC_RAW < 1) ? 1 : BASE_CYC_RAW;
    localparam logic [CRC_W-1:0] CRC_POLY_DEF = 32'h04C11DB7;
    localparam logic [CRC_W-1:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [CRC_W-1:0] ZERO_WORD = 32'h00000000;
    localparam int PASS_LEN_DEF = 64;
    localparam int ADDR_W = 16;
    typedef enum logic [1:0] {
        CCC_IDLE = 2'b00,
        CCC_RUN = 2'b01,
        CCC_DONE = 2'b10
    } ccc_state_t;
endpackage

/* File: design/ccc_checker.sv */
/*
 * Background CRC checker for configuration memory cells: walks the memory
 * bit by bit, folds it into a CRC, compares with the expected value and
 * drives the failure output per completed pass. Expected value is a JTAG
 * scan chain. Assumes memory data comes from logic on clk, tdi/tck pins are
 * asynchronous and pass through three-flop synchronisers.
 */
// Behaviour
// - A 32-bit compare result register holds computed CRC xor expected value, zero meaning no error.
// - The failure output is its own register, loaded with the OR of computed CRC xor expected value alongside the compare result register.
// - At the end of configuration the expected value register is loaded with the precomputed signature.
// - In user mode the expected value is fed to the compute-and-compare unit.
// - With the scan instruction active, the expected value register is a 32-bit chain from tdi to tdo.
// - A JTAG host may rewrite the expected value to inject an error, and the checker then uses it.
// - Scanning does not halt the checker or user logic.
// - With detection enabled, checking starts by itself on entering user mode.
// - The failure output is low until a completed pass finds corruption, then high.
// - The failure output stays high through the next pass and reflects only the latest pass.
// - A completed clean pass returns the failure output low.
// - The checker runs pass after pass until reset.
// - The checker steps at the oscillator rate divided by 2 to the n, 80 MHz at most; the code steps at 62.5 MHz (BASE_CYC = 4 cycles) divided by 2 to the n.
// - The exponent n runs 0 to 8, divisor 1 to 256, slowest 244.140625 kHz.
`timescale 1ns/10ps
module ccc_checker
    import ccc_pkg::*;
#(
    parameter logic [CRC_W-1:0] CRC_POLY = CRC_POLY_DEF,
    parameter int PASS_LEN = PASS_LEN_DEF
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration status
    input wire logic configDone,
    input wire logic userMode,
    input wire logic detectEnable,
    input wire logic [DIV_W-1:0] divExp,
    input wire logic [CRC_W-1:0] precomputedSig,
    // Configuration memory read port
    output logic [ADDR_W-1:0] cellAddr,
    input wire logic cellBit,
    // JTAG scan of the expected value
    input wire logic expected_value_scan_instr,
    input wire logic tck,
    input wire logic tdi,
    input wire logic shiftDr,
    output logic tdo,
    // Status
    output logic [CRC_W-1:0] crc_compare_result,
    output logic [CRC_W-1:0] crc_expected_value,
    output logic passDone,
    output logic crcError
);
    import ccc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Three-flop synchronisers for the JTAG pins
    logic [2:0] tckSync_q, tckSync_d;
    logic [2:0] tdiSync_q, tdiSync_d;
    logic tckSeen_q, tckSeen_d;
    logic tckRise;

    always_comb
    begin
        tckSync_d = {tckSync_q[1:0], tck};
        tdiSync_d = {tdiSync_q[1:0], tdi};
        tckSeen_d = tckSeen_q;
        // Change counts once the second and third stages agree
        if (tckSync_q[1] == tckSync_q[2])
        begin
            tckSeen_d = tckSync_q[2];
        end
        tckRise = (tckSync_q[1] == tckSync_q[2]) && tckSync_q[2] && !tckSeen_q;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tckSync_q <= 3'h0;
            tdiSync_q <= 3'h0;
            tckSeen_q <= 1'b0;
        end
        else
        begin
            tckSync_q <= tckSync_d;
            tdiSync_q <= tdiSync_d;
            tckSeen_q <= tckSeen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Expected value register and scan chain
    logic [CRC_W-1:0] expected_q, expected_d;
    logic cfgDoneDly_q, cfgDoneDly_d;

    always_comb
    begin
        expected_d = expected_q;
        cfgDoneDly_d = configDone;
        if (configDone && !cfgDoneDly_q)
        begin
            expected_d = precomputedSig;
        end
        else if (expected_value_scan_instr && shiftDr && tckRise)
        begin
            // Shift toward bit 0; the checker keeps running meanwhile
            expected_d = {tdiSync_q[2], expected_q[CRC_W-1:1]};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            expected_q <= ZERO_WORD;
            cfgDoneDly_q <= 1'b0;
        end
        else
        begin
            expected_q <= expected_d;
            cfgDoneDly_q <= cfgDoneDly_d;
        end
    end

    assign crc_expected_value = expected_q;
    assign tdo = expected_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Divided step tick: BASE_CYC system cycles times 2**n
    localparam int STEP_W = TICK_W + 2;
    logic [STEP_W-1:0] stepCnt_q, stepCnt_d;
    logic [STEP_W-1:0] stepLen;
    logic step;
    logic [DIV_W-1:0] divSat;

    // Base step is rounded up: the rate stays under the ceiling, so the slowest rate sits a little low
    always_comb
    begin
        divSat = (divExp > DIV_MAX) ? DIV_MAX : divExp;
        stepLen = STEP_W'(BASE_CYC) * STEP_W'({TICK_ONE << divSat});
        step = (stepCnt_q >= stepLen - STEP_W'(1));
        stepCnt_d = step ? '0 : stepCnt_q + STEP_W'(1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stepCnt_q <= '0;
        end
        else
        begin
            stepCnt_q <= stepCnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pass engine
    ccc_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [CRC_W-1:0] crc_q, crc_d;
    logic [CRC_W-1:0] result_q, result_d;
    logic err_q, err_d;
    logic fb;

    always_comb
    begin
        state_d = state_q;
        addr_d = addr_q;
        crc_d = crc_q;
        result_d = result_q;
        err_d = err_q;
        passDone = 1'b0;
        fb = crc_q[CRC_W-1] ^ cellBit;
        case (state_q)
            CCC_IDLE:
            begin
                if (userMode && detectEnable)
                begin
                    state_d = CCC_RUN;
                    addr_d = '0;
                    crc_d = CRC_INIT;
                end
            end
            CCC_RUN:
            begin
                if (step)
                begin
                    crc_d = {crc_q[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : ZERO_WORD);
                    if (addr_q == ADDR_W'(PASS_LEN - 1))
                    begin
                        state_d = CCC_DONE;
                    end
                    else
                    begin
                        addr_d = addr_q + ADDR_W'(1);
                    end
                end
            end
            CCC_DONE:
            begin
                passDone = 1'b1;
                result_d = crc_q ^ expected_q;
                err_d = |(crc_q ^ expected_q);
                state_d = CCC_RUN;
                addr_d = '0;
                crc_d = CRC_INIT;
            end
            default:
            begin
                state_d = CCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= CCC_IDLE;
            addr_q <= '0;
            crc_q <= CRC_INIT;
            result_q <= ZERO_WORD;
            err_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            addr_q <= addr_d;
            crc_q <= crc_d;
            result_q <= result_d;
            err_q <= err_d;
        end
    end

    assign cellAddr = addr_q;
    assign crc_compare_result = result_q;
    assign crcError = err_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence passEnd;
        state_q == CCC_DONE;
    endsequence

    a_err_from_result: assert property (crcError == (|crc_compare_result))
        else $error("failure output disagrees with compare result");
    a_err_holds_pass: assert property (!passDone |=> $stable(crcError))
        else $error("failure output changed outside a pass end");
    a_result_on_end: assert property (passEnd |=> crc_compare_result == ($past(crc_q) ^ $past(expected_q)))
        else $error("compare result wrong after pass end");
    a_err_set_bad: assert property (passEnd and (crc_q != expected_q) |=> crcError)
        else $error("mismatch did not raise failure output");
    a_err_clear_ok: assert property (passEnd and (crc_q == expected_q) |=> !crcError)
        else $error("clean pass did not lower failure output");
    a_loop_restart: assert property (passEnd |=> state_q == CCC_RUN && cellAddr == '0)
        else $error("checker did not restart after pass");
    a_auto_start: assert property (state_q == CCC_IDLE && userMode && detectEnable |=> state_q == CCC_RUN)
        else $error("checker did not start in user mode");
    a_sig_load: assert property ($rose(configDone) |=> crc_expected_value == $past(precomputedSig))
        else $error("expected value not loaded at configuration end");
    a_scan_shift: assert property (expected_value_scan_instr && shiftDr && tckRise && !(configDone && !cfgDoneDly_q)
        |=> tdo == $past(expected_q[1]))
        else $error("scan chain did not shift");
    a_scan_no_halt: assert property (state_q == CCC_RUN && step && addr_q != ADDR_W'(PASS_LEN - 1)
        |=> cellAddr == $past(addr_q) + ADDR_W'(1))
        else $error("checker stalled");
    a_step_rate: assert property (step |=> (!step) [*3])
        else $error("step faster than oscillator limit");
    a_step_len: assert property ($stable(divExp) && divExp >= DIV_MAX && step
        |-> stepCnt_q == STEP_W'(BASE_CYC) * STEP_W'(256) - STEP_W'(1))
        else $error("slowest divider is not 256");
endmodule

/* File: sim/ccc_mem_host.sv */
/* Far-side model: configuration memory cells and a JTAG host that scans the expected value.
   Assumes one clk domain; tck is made from clk and stands still between scans. */
`timescale 1ns/10ps
module ccc_mem_host
    import ccc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Configuration memory read port
    input wire logic [ADDR_W-1:0] cellAddr,
    output logic cellBit,
    // JTAG host
    output logic instr,
    output logic tck,
    output logic tdi,
    output logic shiftDr,
    input wire logic tdo
);
    // Fixed cell pattern, read in the same cycle
    assign cellBit = ^(cellAddr[3:0] ^ 4'hA);

    initial
    begin
        instr = 1'b0;
        tck = 1'b0;
        tdi = 1'b0;
        shiftDr = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Six clk per tck level keeps clear of the three-flop synchroniser
    task automatic scan(input logic [CRC_W-1:0] v, output logic [CRC_W-1:0] old);
        @(posedge clk);
        #1;
        instr = 1'b1;
        shiftDr = 1'b1;
        for (int i = 0; i < CRC_W; i++)
        begin
            tdi = v[i];
            repeat (6) @(posedge clk);
            #1;
            old[i] = tdo;
            tck = 1'b1;
            repeat (6) @(posedge clk);
            #1;
            tck = 1'b0;
        end
        repeat (6) @(posedge clk);
        #1;
        instr = 1'b0;
        shiftDr = 1'b0;
        // Released data line must not keep its last value
        tdi = ~tdi;
    endtask
endmodule

/* File: sim/ccc_checker_tb_top.sv */
/* Testbench for the CRC checker: load, clean pass, scan injection, divider.
   Assumes ccc_mem_host models the memory cells and the JTAG host. */
`timescale 1ns/10ps
module ccc_checker_tb_top;
    import ccc_pkg::*;
    localparam int PL = 8;
    localparam logic [CRC_W-1:0] BAD = 32'h5A5A0F0F;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic configDone = 1'b0;
    logic userMode = 1'b0;
    logic detectEnable = 1'b0;
    logic [DIV_W-1:0] divExp = 4'h0;
    logic [CRC_W-1:0] sig = 32'h00000000;
    logic [ADDR_W-1:0] cellAddr;
    logic cellBit, instr, tck, tdi, shiftDr, tdo, passDone, crcError;
    logic [CRC_W-1:0] result, expVal, golden, got;
    int n_mismatch = 0;
    int checks = 0;
    int passCnt = 0;
    int p0, p1, p8, p9;

    always #2 clk = ~clk;
    always @(posedge clk) if (passDone === 1'b1) passCnt++;

    ccc_checker #(.PASS_LEN(PL)) ccc_checker_i (.clk(clk), .rst(rst), .configDone(configDone),
        .userMode(userMode), .detectEnable(detectEnable), .divExp(divExp), .precomputedSig(sig),
        .cellAddr(cellAddr), .cellBit(cellBit), .expected_value_scan_instr(instr), .tck(tck),
        .tdi(tdi), .shiftDr(shiftDr), .tdo(tdo), .crc_compare_result(result),
        .crc_expected_value(expVal), .passDone(passDone), .crcError(crcError));
    ccc_mem_host host_i (.clk(clk), .cellAddr(cellAddr), .cellBit(cellBit), .instr(instr),
        .tck(tck), .tdi(tdi), .shiftDr(shiftDr), .tdo(tdo));

    ////////////////////////////////////////////////////////////////////////////
    // MSB-first, all-ones start, no final inversion
    function automatic logic [CRC_W-1:0] goldCrc();
        logic [CRC_W-1:0] c;
        logic [ADDR_W-1:0] a;
        c = CRC_INIT;
        for (int i = 0; i < PL; i++)
        begin
            a = ADDR_W'(i);
            c = {c[30:0], 1'b0} ^ (((^(a[3:0] ^ 4'hA)) ^ c[31]) ? CRC_POLY_DEF : ZERO_WORD);
        end
        return c;
    endfunction

    task automatic check(input string name, input logic [CRC_W-1:0] seen, input logic [CRC_W-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Returns at the pass-end cycle; cyc counts cycles since the call
    task automatic waitPass(input logic chk, input logic hold, output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk);
            #2;
            cyc++;
            if (chk && crcError !== hold)
                check("flag during pass", crcError, hold);
        end while (passDone !== 1'b1 && cyc < 20000);
        if (cyc >= 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic scLoad();
        int c;
        golden = goldCrc();
        @(posedge clk);
        #1;
        sig = golden;
        configDone = 1'b1;
        repeat (50) @(posedge clk);
        #1;
        check("expected value", expVal, golden);
        check("passes before enable", passCnt, 0);
        userMode = 1'b1;
        detectEnable = 1'b1;
        waitPass(1'b1, 1'b0, c);
        @(posedge clk);
        #2;
        check("clean result", result, ZERO_WORD);
        check("clean flag", crcError, 1'b0);
    endtask

    task automatic scInject();
        int c;
        int n;
        n = passCnt;
        host_i.scan(BAD, got);
        check("scanned out", got, golden);
        check("scanned in", expVal, BAD);
        check("passes during scan", 32'(passCnt > n + 10), 32'h1);
        waitPass(1'b0, 1'b0, c);
        waitPass(1'b0, 1'b0, c);
        @(posedge clk);
        #2;
        check("error result", result, golden ^ BAD);
        check("error flag", crcError, 1'b1);
        waitPass(1'b1, 1'b1, c);
        host_i.scan(golden, got);
        check("restored out", got, BAD);
        waitPass(1'b0, 1'b0, c);
        waitPass(1'b0, 1'b0, c);
        @(posedge clk);
        #2;
        check("restored flag", crcError, 1'b0);
        check("restored result", result, ZERO_WORD);
    endtask

    task automatic period(input logic [DIV_W-1:0] n, output int p);
        int c;
        @(posedge clk);
        #1;
        divExp = n;
        waitPass(1'b0, 1'b0, c);
        waitPass(1'b0, 1'b0, p);
    endtask

    task automatic scDivider();
        period(4'h0, p0);
        period(4'h1, p1);
        period(4'h8, p8);
        period(4'h9, p9);
        check("divide by two", p1 - p0, PL * BASE_CYC);
        check("divide by 256", p8 - p0, PL * BASE_CYC * 255);
        check("saturated exponent", p9, p8);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        scLoad();
        scInject();
        scDivider();
        stop_test();
    end
endmodule
